// ===== bench/slcd_ctrl_bench.sv
`include "slcd_params.svh"
`define CHK(got, exp) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) \
        begin \
            mismatches++; \
            $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp); \
        end \
    end

module slcd_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import slcd_pkg::*;
    logic mclk, rst_n, sub_clk_en, sleep_mode, cpu_reset, wdt_lowpower_reset;
    logic com45_panel_owned, bias_path_on, pump_on, supply_source_sel;
    logic all_float, all_low;
    logic [1:0] bias_current_sel, pump_voltage_sel, cnt;
    logic [2:0] active_com;
    logic [7:0] sfr_rdata, mem_rdata, d;
    slcd_sfr_req_t sfr_req;
    slcd_mem_req_t mem_req;
    slcd_drive_t [`SLCD_NUM_COM-1:0] com_drv;
    slcd_drive_t [`SLCD_NUM_SEG-1:0] seg_drv;
    int mismatches = 0;
    int num_checks = 0;
    int n;

    slcd_ctrl dut (.mclk, .rst_n, .sub_clk_en, .sleep_mode, .cpu_reset,
        .wdt_lowpower_reset, .sfr_req, .sfr_rdata, .mem_req, .mem_rdata,
        .com_drv, .seg_drv, .com45_panel_owned, .bias_current_sel,
        .bias_path_on, .pump_on, .pump_voltage_sel, .supply_source_sel);
    slcd_panel panel (.com_drv, .seg_drv, .all_float, .all_low, .active_com);

    // Clock and sub clock tick every fourth cycle
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk)
    begin
        cnt <= rst_n ? cnt + 2'h1 : 2'h0;
        sub_clk_en <= (cnt == 2'h3);
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic sfr_wr(input logic idx, input logic [7:0] v);
        @(posedge mclk);
        sfr_req <= '{wr: 1'b1, idx: idx, wdata: v};
        @(posedge mclk);
        sfr_req.wr <= 1'b0;
        #1;
    endtask

    task automatic sfr_rd(input logic idx, output logic [7:0] v);
        @(posedge mclk);
        sfr_req <= '{wr: 1'b0, idx: idx, wdata: 8'h00};
        @(posedge mclk);
        #1 v = sfr_rdata;
    endtask

    task automatic mem_acc(input logic wr, input logic [4:0] a,
                           input logic [7:0] v);
        @(posedge mclk);
        mem_req <= '{wr: wr, addr: a, wdata: v};
        @(posedge mclk);
        mem_req.wr <= 1'b0;
        #1 d = mem_rdata;
    endtask

    task automatic settle(input int c);
        repeat (c) @(posedge mclk);
        #1;
    endtask

    // Wait for the next common to be selected, counting cycles
    task automatic wait_next();
        logic [2:0] prev;
        prev = active_com;
        n = 0;
        while (active_com === prev && n < 300)
        begin
            @(posedge mclk);
            #1 n++;
        end
        if (n == 300)
        begin
            mismatches++;
            conclude();
        end
    endtask

    task automatic scan(input logic [7:0] ctl, input logic [7:0] pwr,
                        input int nc, input int per);
        sfr_wr(1'b0, 8'h00);
        sfr_wr(1'b1, pwr);
        sfr_wr(1'b0, ctl);
        // First change is the entry into slot zero, then one per slot
        for (int k = 0; k <= nc; k++)
        begin
            wait_next();
            `CHK(active_com, 3'(k % nc))
            if (k > 1)
                `CHK(n, per)
        end
        $display("scan test %0h done", ctl);
    endtask

    initial
    begin
        {rst_n, sleep_mode, cpu_reset, wdt_lowpower_reset} = 4'h0;
        {sfr_req, mem_req} = '0;
        settle(10);
        rst_n <= 1'b1;
        sfr_rd(1'b0, d);
        `CHK(d, 8'h00)
        sfr_rd(1'b1, d);
        `CHK(d, 8'h00)
        sfr_wr(1'b0, 8'hFF);
        sfr_rd(1'b0, d);
        `CHK(d, 8'h87)
        sfr_wr(1'b1, 8'hFF);
        sfr_rd(1'b1, d);
        `CHK(d, 8'h1B)
        `CHK(pump_on, 1'b1)
        for (int i = 0; i < 4; i++)
        begin
            sfr_wr(1'b1, 8'(i));
            sfr_wr(1'b0, 8'(i * 2));
            `CHK({pump_voltage_sel, pump_on}, {2'(i), 1'b0})
            `CHK(bias_current_sel, 2'(i))
        end
        $display("register test done");
        mem_acc(1'b1, 5'h00, 8'h01);
        mem_acc(1'b1, 5'h10, 8'hAA);
        mem_acc(1'b0, 5'h10, 8'h00);
        `CHK(d, 8'h00)
        sfr_wr(1'b1, 8'h00);
        sfr_wr(1'b0, 8'h01);
        settle(3);
        `CHK({com_drv[0].level, com_drv[1].level}, 4'hD)
        `CHK({seg_drv[0].level, seg_drv[1].level}, 4'h2)
        `CHK(com_drv[4].oe, 1'b0)
        scan(8'h01, 8'h00, 4, 64);
        scan(8'h01, 8'h10, 6, 64);
        scan(8'h81, 8'h10, 6, 32);
        mem_acc(1'b0, 5'h10, 8'h00);
        `CHK(d, 8'hAA)
        sfr_wr(1'b0, 8'h00);
        settle(3);
        `CHK({all_low, bias_path_on}, 2'h2)
        sfr_wr(1'b1, 8'h08);
        sfr_wr(1'b0, 8'h01);
        `CHK(pump_on, 1'b1)
        sleep_mode <= 1'b1;
        settle(3);
        `CHK({all_low, pump_on, bias_path_on}, 3'h4)
        sleep_mode <= 1'b0;
        {cpu_reset, wdt_lowpower_reset} <= 2'h3;
        settle(5);
        `CHK(all_float, 1'b0)
        cpu_reset <= 1'b0;
        sfr_rd(1'b0, d);
        `CHK(d, 8'h01)
        {cpu_reset, wdt_lowpower_reset} <= 2'h2;
        settle(3);
        `CHK(all_float, 1'b1)
        cpu_reset <= 1'b0;
        settle(400);
        `CHK(all_float, 1'b1)
        settle(20);
        `CHK(all_float, 1'b0)
        $display("reset test done");
        conclude();
    end
endmodule

// ===== bench/slcd_ctrl_props.sv
`include "slcd_params.svh"

module slcd_ctrl_props (
    input wire logic                                 mclk,
    input wire logic                                 rst_n,
    input wire logic                                 sleep_mode,
    input wire logic                                 cpu_reset,
    input wire logic                                 wdt_lowpower_reset,
    input wire slcd_pkg::slcd_sfr_req_t              sfr_req,
    input wire logic [7:0]                           sfr_rdata,
    input wire slcd_pkg::slcd_drive_t [`SLCD_NUM_COM-1:0] com_drv,
    input wire slcd_pkg::slcd_drive_t [`SLCD_NUM_SEG-1:0] seg_drv,
    input wire logic                                 com45_panel_owned,
    input wire logic [1:0]                           bias_current_sel,
    input wire logic                                 bias_path_on,
    input wire logic                                 pump_on,
    input wire logic [1:0]                           pump_voltage_sel,
    input wire logic                                 supply_source_sel
);
    timeunit 1ns;
    timeprecision 1ns;
    import slcd_pkg::*;
    logic [7:0] ctl_reg;
    logic [7:0] pwr_reg;
    logic [8:0] fcnt_reg;
    logic [1:0] age_reg;
    logic       eff;
    logic       ok;
    logic       any_oe;
    logic       all_low;

    // Output summaries and settled-state guard
    always_comb
    begin
        eff = cpu_reset & ~wdt_lowpower_reset;
        ok = (age_reg == 2'h3) && (fcnt_reg == 9'h000) && !eff;
        any_oe = 1'b0;
        all_low = 1'b1;
        for (int i = 0; i < `SLCD_NUM_COM; i++)
        begin
            any_oe |= com_drv[i].oe;
            all_low &= (com_drv[i].level == `SLCD_LVL_VSS);
        end
        for (int i = 0; i < `SLCD_NUM_SEG; i++)
        begin
            any_oe |= seg_drv[i].oe;
            all_low &= (seg_drv[i].level == `SLCD_LVL_VSS);
        end
    end

    // Shadow registers, float window and age after reset
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctl_reg <= 8'h00;
            pwr_reg <= 8'h00;
            fcnt_reg <= 9'h000;
            age_reg <= 2'h0;
        end
        else
        begin
            age_reg <= (age_reg == 2'h3) ? age_reg : age_reg + 2'h1;
            fcnt_reg <= eff ? 9'h19A : fcnt_reg - {8'h00, |fcnt_reg};
            if (eff)
            begin
                ctl_reg <= 8'h00;
                pwr_reg <= 8'h00;
            end
            else if (sfr_req.wr && !sfr_req.idx)
                ctl_reg <= sfr_req.wdata;
            else if (sfr_req.wr)
                pwr_reg <= sfr_req.wdata;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_pump_gate: assert property (
        ok |-> pump_on == (ctl_reg[0] & ~sleep_mode & pwr_reg[3]))
        else $error("pump enable mismatch");
    a_bias_field: assert property (
        ok |-> bias_current_sel == ctl_reg[2:1])
        else $error("bias current select mismatch");
    a_power_fields: assert property (
        ok |-> {com45_panel_owned, supply_source_sel, pump_voltage_sel}
            == {pwr_reg[4], pwr_reg[3], pwr_reg[1:0]})
        else $error("power field mismatch");
    a_reserved_zero: assert property (
        !sfr_req.idx |=> sfr_rdata[6:3] == 4'h0)
        else $error("reserved control bits not zero");
    a_float_hold: assert property (
        (fcnt_reg > 9'h002) ##1 (fcnt_reg > 9'h002) |-> !any_oe)
        else $error("outputs driven during processor reset");
    a_watchdog_kept: assert property (
        (ok && cpu_reset && wdt_lowpower_reset)[*2] |-> any_oe)
        else $error("watchdog reset floated outputs");
    a_disable_low: assert property (
        (ok && !ctl_reg[0])[*3] |-> all_low && any_oe)
        else $error("disabled outputs not low");
    a_sleep_low: assert property (
        (ok && sleep_mode)[*3] |-> all_low && !pump_on)
        else $error("sleep outputs not low");
    a_bias_off: assert property (
        (!ctl_reg[0] || sleep_mode)[*2] |-> !bias_path_on)
        else $error("bias path on while disabled");
    a_com45_free: assert property (
        (age_reg == 2'h3 && !pwr_reg[4])[*2]
            |-> !com_drv[4].oe && !com_drv[5].oe)
        else $error("commons 4 and 5 driven at quarter duty");
endmodule

bind slcd_ctrl slcd_ctrl_props u_props (
    .mclk, .rst_n, .sleep_mode, .cpu_reset, .wdt_lowpower_reset, .sfr_req,
    .sfr_rdata, .com_drv, .seg_drv, .com45_panel_owned, .bias_current_sel,
    .bias_path_on, .pump_on, .pump_voltage_sel, .supply_source_sel
);

// ===== bench/slcd_panel.sv
`include "slcd_params.svh"

module slcd_panel (
    input wire slcd_pkg::slcd_drive_t [`SLCD_NUM_COM-1:0] com_drv,
    input wire slcd_pkg::slcd_drive_t [`SLCD_NUM_SEG-1:0] seg_drv,
    output logic                                     all_float,
    output logic                                     all_low,
    output logic [2:0]                               active_com
);
    timeunit 1ns;
    timeprecision 1ns;
    import slcd_pkg::*;

    // Glass view: undriven pins, blank levels, selected backplane
    always_comb
    begin
        all_float = 1'b1;
        all_low = 1'b1;
        active_com = 3'h7;
        for (int i = 0; i < `SLCD_NUM_SEG; i++)
        begin
            all_float &= !seg_drv[i].oe;
            all_low &= (seg_drv[i].level == `SLCD_LVL_VSS);
        end
        for (int i = `SLCD_NUM_COM - 1; i >= 0; i--)
        begin
            all_float &= !com_drv[i].oe;
            all_low &= (com_drv[i].level == `SLCD_LVL_VSS);
            if (com_drv[i].oe && com_drv[i].level[0] == com_drv[i].level[1])
                active_com = 3'(i);
        end
        if (all_low)
            active_com = 3'h7;
    end
endmodule

// ===== verilog/slcd_ctrl.sv
// Function
// - Enable bit acts only outside sleep; sleep always holds display disabled.
// - Control bit 7 picks waveform: zero type A, one type B.
// - Control bits 2..1 pick bias current 25, 50, 100, 200 uA.
// - Control bit 0 enables the display driver.
// - Power bit 4 picks quarter duty (four commons) or sixth duty (six).
// - Quarter duty drives commons 0..3 only and releases commons 4 and 5.
// - Power bit 3 picks supply pin (pump off) or internal charge pump.
// - Power bits 1..0 pick pump level 3.3, 3.0, 2.7 or 4.5 volts.
// - Charge pump runs only when enable and supply source bits are both set.
// - Bias network DC path is off whenever the driver is disabled.
// - Display reset is inverted enable OR sleep.
// - Clearing enable resets display and drives all in-use commons and segments low.
// - Entering sleep resets display and drives outputs low despite enable set.
// - Processor reset floats outputs for reset delay plus settle time.
// - Watchdog reset in idle or sleep does not count as processor reset.
// - Panel is 32x4 or 30x6 with one-third resistor bias.
// - Duty sets the number of time slots in each frame.
// - Disabled driver stops drive signals, giving a blank low-power panel.
// - All control fields, enable included, reset to zero at power-on.
// - Control bits 6..3 read back as zero.
// - Type B runs at a lower signal frequency than type A.
// - Display clock is the sub clock divided by eight.
// - Memory rows of commons 4 and 5 read zero at quarter duty.
`include "slcd_params.svh"

module slcd_ctrl (
    input  wire logic                                  mclk,
    input  wire logic                                  rst_n,
    input  wire logic                                  sub_clk_en,
    input  wire logic                                  sleep_mode,
    input  wire logic                                  cpu_reset,
    input  wire logic                                  wdt_lowpower_reset,
    input  wire slcd_pkg::slcd_sfr_req_t               sfr_req,
    output logic [7:0]                                 sfr_rdata,
    input  wire slcd_pkg::slcd_mem_req_t               mem_req,
    output logic [7:0]                                 mem_rdata,
    output slcd_pkg::slcd_drive_t [`SLCD_NUM_COM-1:0]  com_drv,
    output slcd_pkg::slcd_drive_t [`SLCD_NUM_SEG-1:0]  seg_drv,
    output logic                                       com45_panel_owned,
    output logic [1:0]                                 bias_current_sel,
    output logic                                       bias_path_on,
    output logic                                       pump_on,
    output logic [1:0]                                 pump_voltage_sel,
    output logic                                       supply_source_sel
);
    import slcd_pkg::*;

    // Common level for one slot half: selected swings full, others a third
    function automatic logic [1:0] com_level(input logic sel,
                                             input logic pol);
        if (sel)
            com_level = pol ? `SLCD_LVL_VSS : `SLCD_LVL_VA;
        else
            com_level = pol ? `SLCD_LVL_VB : `SLCD_LVL_VC;
    endfunction

    // Segment level: on opposes the selected common, off sits near it
    function automatic logic [1:0] seg_level(input logic on,
                                             input logic pol);
        if (on)
            seg_level = pol ? `SLCD_LVL_VA : `SLCD_LVL_VSS;
        else
            seg_level = pol ? `SLCD_LVL_VC : `SLCD_LVL_VB;
    endfunction

    // Register port and display memory storage
    logic [7:0]        control_reg;
    logic [7:0]        power_reg;
    logic [31:0]       mem_reg [`SLCD_NUM_COM];

    // Panel sequencer state
    logic [2:0]        div_reg;
    logic [2:0]        slot_reg;
    logic [2:0]        slot_next;
    logic              phase_reg;
    logic              phase_next;
    logic              frame_pol_reg;
    logic              frame_pol_next;
    logic [15:0]       float_cnt_reg;
    slcd_state_t       state_reg;
    slcd_state_t       state_next;
    slcd_drive_t [`SLCD_NUM_COM-1:0] com_drv_reg;
    slcd_drive_t [`SLCD_NUM_SEG-1:0] seg_drv_reg;
    logic [7:0]        sfr_rdata_reg;
    logic [7:0]        mem_rdata_reg;

    // Decoded control fields
    wire         wave_type_b  = control_reg[`SLCD_CTL_TYPE_BIT];
    wire         display_enable = control_reg[`SLCD_CTL_EN_BIT];
    wire         duty_select  = power_reg[`SLCD_PWR_DUTY_BIT];
    wire [2:0]   num_com      = duty_select ? `SLCD_COM_6DUTY
                                            : `SLCD_COM_4DUTY;
    wire         mcu_reset    = cpu_reset & ~wdt_lowpower_reset;
    wire         enable_eff   = display_enable & ~sleep_mode;
    wire         display_reset = ~display_enable | sleep_mode;
    wire         disp_tick    = sub_clk_en
                                & (div_reg == `SLCD_SUB_DIV);
    wire         last_slot    = slot_reg == (num_com - 3'h1);
    wire         floating     = mcu_reset || (float_cnt_reg != 16'h0);
    wire         pol          = wave_type_b ? frame_pol_reg
                                            : phase_reg;

    // Readback views with unimplemented bits at zero
    wire [7:0]   control_view = {wave_type_b, 4'h0,
                                 control_reg[`SLCD_CTL_BIAS_HI:
                                             `SLCD_CTL_BIAS_LO],
                                 display_enable};
    wire [7:0]   power_view   = {3'h0, duty_select,
                                 power_reg[`SLCD_PWR_SRC_BIT], 1'b0,
                                 power_reg[`SLCD_PWR_PUMP_HI:
                                           `SLCD_PWR_PUMP_LO]};
    wire [7:0]   sfr_view     = (sfr_req.idx == `SLCD_IDX_POWER)
                                ? power_view : control_view;

    // Memory read decode: row per common, four bytes per row
    wire [2:0]   mem_row      = mem_req.addr[4:2];
    wire [1:0]   mem_byte     = mem_req.addr[1:0];
    wire         mem_in_range = mem_req.addr < `SLCD_MEM_BYTES;
    wire         mem_row_live = mem_in_range
                                & (duty_select | (mem_row < 3'h4));
    wire [31:0]  mem_row_data = mem_in_range ? mem_reg[mem_row]
                                             : 32'h0;
    wire [7:0]   mem_view     = mem_row_live
                                ? mem_row_data[{mem_byte, 3'h0} +: 8]
                                : 8'h00;

    // Analog control outputs
    assign bias_current_sel  = control_reg[`SLCD_CTL_BIAS_HI:
                                           `SLCD_CTL_BIAS_LO];
    assign supply_source_sel = power_reg[`SLCD_PWR_SRC_BIT];
    assign pump_voltage_sel  = power_reg[`SLCD_PWR_PUMP_HI:
                                         `SLCD_PWR_PUMP_LO];
    assign pump_on           = enable_eff & supply_source_sel;
    assign bias_path_on      = ~display_reset & ~floating;
    assign com45_panel_owned = duty_select;
    assign com_drv           = com_drv_reg;
    assign seg_drv           = seg_drv_reg;
    assign sfr_rdata         = sfr_rdata_reg;
    assign mem_rdata         = mem_rdata_reg;

    // Output condition: float beats reset beats run
    always_comb
    begin
        if (floating)
            state_next = SLCD_FLOAT;
        else if (display_reset)
            state_next = SLCD_OFF;
        else
            state_next = SLCD_RUN;
    end

    // Slot, half-slot phase and frame polarity sequencing
    always_comb
    begin
        slot_next      = slot_reg;
        phase_next     = phase_reg;
        frame_pol_next = frame_pol_reg;
        if (state_reg != SLCD_RUN)
        begin
            slot_next      = 3'h0;
            phase_next     = 1'b0;
            frame_pol_next = 1'b0;
        end
        else if (disp_tick)
        begin
            if (!wave_type_b && !phase_reg)
                phase_next = 1'b1;
            else
            begin
                phase_next = 1'b0;
                slot_next  = last_slot ? 3'h0 : slot_reg + 3'h1;
                if (last_slot)
                    frame_pol_next = ~frame_pol_reg;
            end
        end
    end

    // Control registers, cleared at power-on and processor reset
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            control_reg <= `SLCD_CTL_RESET;
            power_reg   <= `SLCD_PWR_RESET;
        end
        else if (mcu_reset)
        begin
            control_reg <= `SLCD_CTL_RESET;
            power_reg   <= `SLCD_PWR_RESET;
        end
        else if (sfr_req.wr && sfr_req.idx == `SLCD_IDX_CONTROL)
            control_reg <= sfr_req.wdata;
        else if (sfr_req.wr && sfr_req.idx == `SLCD_IDX_POWER)
            power_reg   <= sfr_req.wdata;
    end

    // Registered read data for both ports
    // Read data follows the index or address of the previous cycle
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sfr_rdata_reg <= 8'h00;
            mem_rdata_reg <= 8'h00;
        end
        else
        begin
            sfr_rdata_reg <= sfr_view;
            mem_rdata_reg <= mem_view;
        end
    end

    // Display memory rows, one byte lane per write
    genvar r;
    generate
        for (r = 0; r < `SLCD_NUM_COM; r++)
        begin : g_row
            wire row_hit = mem_req.wr && mem_in_range
                           && (mem_row == 3'(r));
            // One byte lane of this row per write
            always_ff @(posedge mclk or negedge rst_n)
            begin
                if (!rst_n)
                    mem_reg[r] <= 32'h0;
                else if (row_hit)
                    mem_reg[r][{mem_byte, 3'h0} +: 8] <= mem_req.wdata;
            end
        end
    endgenerate

    // Sub clock divider to display tick
    // Restarts on each entry to run so slot zero starts fresh
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            div_reg <= 3'h0;
        else if (state_reg != SLCD_RUN)
            div_reg <= 3'h0;
        else if (sub_clk_en)
            div_reg <= div_reg + 3'h1;
    end

    // Float hold counter after processor reset release
    // Reloads through the reset, so the window counts from release
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            float_cnt_reg <= 16'h0;
        else if (mcu_reset)
            float_cnt_reg <= 16'(`SLCD_FLOAT_CYCLES);
        else if (float_cnt_reg != 16'h0)
            float_cnt_reg <= float_cnt_reg - 16'h1;
    end

    // Sequencer state
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg     <= SLCD_OFF;
            slot_reg      <= 3'h0;
            phase_reg     <= 1'b0;
            frame_pol_reg <= 1'b0;
        end
        else
        begin
            state_reg     <= state_next;
            slot_reg      <= slot_next;
            phase_reg     <= phase_next;
            frame_pol_reg <= frame_pol_next;
        end
    end

    // Common pin drive
    genvar c;
    generate
        for (c = 0; c < `SLCD_NUM_COM; c++)
        begin : g_com
            wire in_use = (c < 4) || duty_select;
            slcd_drive_t drv_next;
            // Next drive for this common from the output condition
            always_comb
            begin
                drv_next = '0;
                unique case (state_reg)
                    SLCD_FLOAT: drv_next = '0;
                    SLCD_OFF:   drv_next = '{oe: in_use,
                                             level: `SLCD_LVL_VSS};
                    SLCD_RUN:   drv_next = '{oe: in_use,
                                  level: com_level(slot_reg == 3'(c),
                                                   pol)};
                    default:    drv_next = '0;
                endcase
            end

            // Register pin enable and level together
            always_ff @(posedge mclk or negedge rst_n)
            begin
                if (!rst_n)
                    com_drv_reg[c] <= '0;
                else
                    com_drv_reg[c] <= drv_next;
            end
        end
    endgenerate

    // Segment pin drive from the row of the active common
    genvar s;
    generate
        for (s = 0; s < `SLCD_NUM_SEG; s++)
        begin : g_seg
            wire in_use = (s < `SLCD_SEG_6DUTY) || !duty_select;
            wire on     = mem_reg[slot_reg][s];
            slcd_drive_t drv_next;
            // Next drive for this segment from the output condition
            always_comb
            begin
                drv_next = '0;
                unique case (state_reg)
                    SLCD_FLOAT: drv_next = '0;
                    SLCD_OFF:   drv_next = '{oe: in_use,
                                             level: `SLCD_LVL_VSS};
                    SLCD_RUN:   drv_next = '{oe: in_use,
                                  level: seg_level(on, pol)};
                    default:    drv_next = '0;
                endcase
            end

            // Register pin enable and level together
            always_ff @(posedge mclk or negedge rst_n)
            begin
                if (!rst_n)
                    seg_drv_reg[s] <= '0;
                else
                    seg_drv_reg[s] <= drv_next;
            end
        end
    endgenerate

endmodule

// ===== verilog/slcd_params.svh
`ifndef SLCD_PARAMS_SVH
`define SLCD_PARAMS_SVH

// Register indices on the special function port
`define SLCD_IDX_CONTROL       1'b0
`define SLCD_IDX_POWER         1'b1

// Display control field positions
`define SLCD_CTL_TYPE_BIT      7
`define SLCD_CTL_BIAS_HI       2
`define SLCD_CTL_BIAS_LO       1
`define SLCD_CTL_EN_BIT        0
`define SLCD_CTL_RESET         8'h00

// Power control field positions
`define SLCD_PWR_DUTY_BIT      4
`define SLCD_PWR_SRC_BIT       3
`define SLCD_PWR_PUMP_HI       1
`define SLCD_PWR_PUMP_LO       0
`define SLCD_PWR_RESET         8'h00

// Panel geometry
`define SLCD_NUM_COM           6
`define SLCD_NUM_SEG           32
`define SLCD_SEG_6DUTY         30
`define SLCD_COM_4DUTY         3'h4
`define SLCD_COM_6DUTY         3'h6
`define SLCD_MEM_BYTES         5'h18

// Sub clock divider
`define SLCD_SUB_DIV           3'h7

// Float hold after a processor reset
`define SLCD_MCLK_MHZ          10
`define SLCD_RESET_DELAY_US    25
`define SLCD_SETTLE_US         16
`define SLCD_FLOAT_CYCLES      ((`SLCD_RESET_DELAY_US + `SLCD_SETTLE_US) \
                                * `SLCD_MCLK_MHZ)

// Bias levels: 0 = VSS, 1 = VC, 2 = VB, 3 = VA
`define SLCD_LVL_VSS           2'h0
`define SLCD_LVL_VC            2'h1
`define SLCD_LVL_VB            2'h2
`define SLCD_LVL_VA            2'h3

`endif

// ===== verilog/slcd_pkg.sv
package slcd_pkg;

    // One panel pin: drive enable and bias level
    typedef struct packed {
        logic       oe;
        logic [1:0] level;
    } slcd_drive_t;

    // Special function register access
    typedef struct packed {
        logic       wr;
        logic       idx;
        logic [7:0] wdata;
    } slcd_sfr_req_t;

    // Display memory access
    typedef struct packed {
        logic       wr;
        logic [4:0] addr;
        logic [7:0] wdata;
    } slcd_mem_req_t;

    // Output condition of the driver
    typedef enum logic [1:0] {
        SLCD_FLOAT,
        SLCD_OFF,
        SLCD_RUN
    } slcd_state_t;

endpackage
